//--- hw/mla_params.svh
// Summary of operation
// - AND of accumulator with memory or immediate goes to accumulator; zero flag only.
// - Memory-destination AND writes accumulator AND byte back to memory; zero flag only.
// - Call pushes program counter plus one, then loads the target address.
// - Whole-byte clear writes 00h to memory; no flag changes.
// - Bit clear zeroes only the selected bit; other bits and flags kept.
// - Watchdog clear zeroes the watchdog counter and clears power-down and time-out flags.
// - Both pre-clear instructions executed together clear watchdog counter and both flags.
// - One pre-clear alone only records itself; counter and flags unchanged.
// - In-place complement inverts the memory byte; zero flag only.
// - Complement to accumulator inverts the byte into accumulator; memory kept; zero flag only.
// - Low digit above 9 or aux carry: add 6, nibble carry = not aux carry.
// - High digit plus nibble carry above 9 or carry: add 6, set carry; result to memory.
// - Memory decrement stores byte minus one in place; zero flag only.
// - Decrement to accumulator loads byte minus one; memory kept; zero flag only.
// - Power-down halts execution, stops the clock, keeps state, advances program counter.
// - Power-down clears watchdog counter and prescaler, sets power-down flag, clears time-out.
// - Memory increment stores byte plus one in place; zero flag only.
// - Increment to accumulator loads byte plus one; memory kept; zero flag only.
// - Jump loads the program counter with the operand target address; no flags change.
// - Moves copy memory to accumulator, accumulator to memory, or immediate; no flags.
// - No-operation only advances the program counter by one.
// - OR of accumulator with memory or immediate goes to accumulator; zero flag only.
// - Flags an instruction does not affect keep their previous values.
`ifndef MLA_PARAMS_SVH
`define MLA_PARAMS_SVH

`define MLA_OFS_INSTR 12'h000
`define MLA_OFS_OPERAND 12'h004
`define MLA_OFS_ACCUM 12'h008
`define MLA_OFS_STATUS 12'h00c
`define MLA_OFS_PC 12'h010
`define MLA_OFS_WDOG 12'h014
`define MLA_OFS_DMEM 12'h040

`define MLA_INSTR_OP_LSB 0
`define MLA_INSTR_BIT_LSB 8
`define MLA_INSTR_ADDR_LSB 16
`define MLA_OPND_IMM_LSB 0
`define MLA_OPND_TGT_LSB 16

`define MLA_ST_C 0
`define MLA_ST_AUX 1
`define MLA_ST_Z 2
`define MLA_ST_OVFL 3
`define MLA_ST_PWRDN 4
`define MLA_ST_TMO 5
`define MLA_ST_HALT 6
`define MLA_ST_PRE1 7
`define MLA_ST_PRE2 8
`define MLA_ST_W 9

`define MLA_ACCUM_RST 8'h00
`define MLA_BYTE_ZERO 8'h00
`define MLA_PC_RST 12'h000
`define MLA_PC_STEP 12'h001
`define MLA_BYTE_ONE 8'h01
`define MLA_BCD_MAX 5'h09
`define MLA_BCD_ADJ 5'h06
`define MLA_PRESC_DIV 16'h00ff
`define MLA_WDOG_MAX 8'hff

`endif

//--- hw/mla_pkg.sv
package mla_pkg;

	typedef enum logic [5:0] {
		mla_op_nop = 6'h00,
		mla_op_and_mem = 6'h01,
		mla_op_and_imm = 6'h02,
		mla_op_and_to_memory = 6'h03,
		mla_op_call = 6'h04,
		mla_op_clr_byte = 6'h05,
		mla_op_clr_bit = 6'h06,
		mla_op_watchdog_clear = 6'h07,
		mla_op_watchdog_preclear_first = 6'h08,
		mla_op_watchdog_preclear_second = 6'h09,
		mla_op_complement_in_place = 6'h0a,
		mla_op_complement_to_acc = 6'h0b,
		mla_op_decimal_adjust = 6'h0c,
		mla_op_dec_mem = 6'h0d,
		mla_op_decrement_to_acc = 6'h0e,
		mla_op_power_down = 6'h0f,
		mla_op_inc_mem = 6'h10,
		mla_op_increment_to_acc = 6'h11,
		mla_op_jump = 6'h12,
		mla_op_mov_mem_to_accum = 6'h13,
		mla_op_mov_imm = 6'h14,
		mla_op_mov_accum_to_mem = 6'h15,
		mla_op_or_mem = 6'h16,
		mla_op_or_imm = 6'h17
	} mla_op_t;

	typedef enum logic [1:0] {
		mla_run = 2'b01,
		mla_halted = 2'b10
	} mla_state_t;

endpackage

//--- hw/mla_exec_unit.sv
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mla_params.svh"

module mla_exec_unit #(
	parameter int DMEM_AW = 4,
	parameter int STACK_AW = 4,
	parameter int PC_W = 12
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_wake,
	output logic o_halted,
	output logic o_clk_stop,
	output logic o_timeout_flag
);

	localparam int DMEM_DEPTH = 1 << DMEM_AW;
	localparam int STACK_DEPTH = 1 << STACK_AW;

	logic rst_sync1_reg;
	logic rst_sync2_reg;
	logic rst_n;

	logic [7:0] work_accumulator_reg;
	logic [7:0] work_accumulator_next;
	logic [7:0] operand_imm_reg;
	logic [PC_W-1:0] operand_tgt_reg;
	logic carry_reg;
	logic carry_next;
	logic aux_carry_flag_reg;
	logic zero_reg;
	logic zero_next;
	logic overflow_flag_reg;
	logic power_down_flag_reg;
	logic timeout_flag_reg;
	logic preclear_first_reg;
	logic preclear_first_next;
	logic preclear_second_reg;
	logic preclear_second_next;
	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] pc_next;
	logic [STACK_AW-1:0] sp_reg;
	logic [PC_W-1:0] stack_mem [STACK_DEPTH];
	logic [7:0] dmem [DMEM_DEPTH];
	logic [7:0] watchdog_counter_reg;
	logic [15:0] presc_reg;
	mla_pkg::mla_state_t state_reg;

	logic [31:0] rdata_reg;
	logic err_reg;

	logic setup;
	logic wr_access;
	logic exec;
	logic [5:0] op_raw;
	logic [2:0] bit_sel;
	logic [DMEM_AW-1:0] op_addr;
	logic [7:0] mem_byte;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic push;
	logic wdog_clr;
	logic flags_clr;
	logic enter_halt;
	logic op_legal;
	logic presc_tick;
	logic wdog_overflow;
	logic dmem_hit;
	logic [DMEM_AW-1:0] dmem_idx;
	logic addr_known;
	logic [4:0] bcd_lo;
	logic [4:0] bcd_hi;
	logic nibble_carry;

	// Release reset through two flops; the design runs on the synced copy
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end
	assign rst_n = rst_sync2_reg;

	// APB decode
	assign setup = i_psel && !i_penable;
	assign o_pready = i_psel && i_penable;
	assign wr_access = o_pready && i_pwrite;
	assign dmem_hit = (i_paddr >> (DMEM_AW + 2)) == (`MLA_OFS_DMEM >> (DMEM_AW + 2));
	assign dmem_idx = i_paddr[DMEM_AW+1:2];
	assign addr_known = dmem_hit || i_paddr == `MLA_OFS_INSTR || i_paddr == `MLA_OFS_OPERAND ||
		i_paddr == `MLA_OFS_ACCUM || i_paddr == `MLA_OFS_STATUS || i_paddr == `MLA_OFS_PC ||
		i_paddr == `MLA_OFS_WDOG;

	assign op_raw = i_pwdata[`MLA_INSTR_OP_LSB +: 6];
	assign bit_sel = i_pwdata[`MLA_INSTR_BIT_LSB +: 3];
	assign op_addr = i_pwdata[`MLA_INSTR_ADDR_LSB +: DMEM_AW];
	assign mem_byte = dmem[op_addr];
	assign op_legal = op_raw <= 6'(mla_pkg::mla_op_or_imm);
	// No instruction runs while the clock is stopped
	assign exec = wr_access && i_paddr == `MLA_OFS_INSTR && op_legal &&
		state_reg == mla_pkg::mla_run;

	// Read data and address error are captured in setup so both come from flops
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0000_0000;
			err_reg <= 1'b0;
		end else if (setup) begin
			err_reg <= !addr_known || (i_pwrite && (i_paddr == `MLA_OFS_PC || i_paddr == `MLA_OFS_WDOG));
			rdata_reg <= 32'h0000_0000;
			if (dmem_hit) begin
				rdata_reg <= {24'h00_0000, dmem[dmem_idx]};
			end else begin
				unique case (i_paddr)
					`MLA_OFS_OPERAND: rdata_reg <= {{(16 - PC_W){1'b0}}, operand_tgt_reg, 8'h00, operand_imm_reg};
					`MLA_OFS_ACCUM: rdata_reg <= {24'h00_0000, work_accumulator_reg};
					`MLA_OFS_STATUS: rdata_reg <= {{(32 - `MLA_ST_W){1'b0}}, preclear_second_reg,
						preclear_first_reg, o_halted, timeout_flag_reg, power_down_flag_reg,
						overflow_flag_reg, zero_reg, aux_carry_flag_reg, carry_reg};
					`MLA_OFS_PC: rdata_reg <= {{(16 - STACK_AW){1'b0}}, sp_reg, {(16 - PC_W){1'b0}}, pc_reg};
					`MLA_OFS_WDOG: rdata_reg <= {24'h00_0000, watchdog_counter_reg};
					default: rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end
	assign o_prdata = rdata_reg;
	// Instruction writes while halted or with an unknown opcode are refused
	assign o_pslverr = o_pready && (err_reg || (i_pwrite && i_paddr == `MLA_OFS_INSTR &&
		(!op_legal || state_reg != mla_pkg::mla_run)));

	// Decimal adjust datapath
	always_comb begin
		if (work_accumulator_reg[3:0] > `MLA_BCD_MAX || aux_carry_flag_reg) begin
			bcd_lo = {1'b0, work_accumulator_reg[3:0]} + `MLA_BCD_ADJ;
			nibble_carry = !aux_carry_flag_reg;
		end else begin
			bcd_lo = {1'b0, work_accumulator_reg[3:0]};
			nibble_carry = 1'b0;
		end
		bcd_hi = {1'b0, work_accumulator_reg[7:4]} + {4'h0, nibble_carry};
	end

	// Instruction semantics; anything not assigned keeps its value, except the program counter, which advances by one
	always_comb begin
		work_accumulator_next = work_accumulator_reg;
		zero_next = zero_reg;
		carry_next = carry_reg;
		mem_we = 1'b0;
		mem_wdata = mem_byte;
		pc_next = pc_reg + `MLA_PC_STEP;
		push = 1'b0;
		wdog_clr = 1'b0;
		flags_clr = 1'b0;
		enter_halt = 1'b0;
		preclear_first_next = preclear_first_reg;
		preclear_second_next = preclear_second_reg;
		unique case (mla_pkg::mla_op_t'(op_raw))
			mla_pkg::mla_op_and_mem: work_accumulator_next = work_accumulator_reg & mem_byte;
			mla_pkg::mla_op_and_imm: work_accumulator_next = work_accumulator_reg & operand_imm_reg;
			mla_pkg::mla_op_and_to_memory: begin
				mem_we = 1'b1;
				mem_wdata = work_accumulator_reg & mem_byte;
			end
			mla_pkg::mla_op_call: begin
				push = 1'b1;
				pc_next = operand_tgt_reg;
			end
			mla_pkg::mla_op_clr_byte: begin
				mem_we = 1'b1;
				mem_wdata = `MLA_BYTE_ZERO;
			end
			mla_pkg::mla_op_clr_bit: begin
				mem_we = 1'b1;
				mem_wdata[bit_sel] = 1'b0;
			end
			mla_pkg::mla_op_watchdog_clear: begin
				wdog_clr = 1'b1;
				flags_clr = 1'b1;
			end
			mla_pkg::mla_op_watchdog_preclear_first: begin
				if (preclear_second_reg) begin
					wdog_clr = 1'b1;
					flags_clr = 1'b1;
					preclear_second_next = 1'b0;
				end else begin
					preclear_first_next = 1'b1;
				end
			end
			mla_pkg::mla_op_watchdog_preclear_second: begin
				if (preclear_first_reg) begin
					wdog_clr = 1'b1;
					flags_clr = 1'b1;
					preclear_first_next = 1'b0;
				end else begin
					preclear_second_next = 1'b1;
				end
			end
			mla_pkg::mla_op_complement_in_place: begin
				mem_we = 1'b1;
				mem_wdata = ~mem_byte;
			end
			mla_pkg::mla_op_complement_to_acc: work_accumulator_next = ~mem_byte;
			mla_pkg::mla_op_decimal_adjust: begin
				mem_we = 1'b1;
				if (bcd_hi > `MLA_BCD_MAX || carry_reg) begin
					mem_wdata = {4'(bcd_hi + `MLA_BCD_ADJ), bcd_lo[3:0]};
					carry_next = 1'b1;
				end else begin
					mem_wdata = {bcd_hi[3:0], bcd_lo[3:0]};
				end
			end
			mla_pkg::mla_op_dec_mem: begin
				mem_we = 1'b1;
				mem_wdata = mem_byte - `MLA_BYTE_ONE;
			end
			mla_pkg::mla_op_decrement_to_acc: work_accumulator_next = mem_byte - `MLA_BYTE_ONE;
			mla_pkg::mla_op_power_down: begin
				enter_halt = 1'b1;
				wdog_clr = 1'b1;
			end
			mla_pkg::mla_op_inc_mem: begin
				mem_we = 1'b1;
				mem_wdata = mem_byte + `MLA_BYTE_ONE;
			end
			mla_pkg::mla_op_increment_to_acc: work_accumulator_next = mem_byte + `MLA_BYTE_ONE;
			mla_pkg::mla_op_jump: pc_next = operand_tgt_reg;
			mla_pkg::mla_op_mov_mem_to_accum: work_accumulator_next = mem_byte;
			mla_pkg::mla_op_mov_imm: work_accumulator_next = operand_imm_reg;
			mla_pkg::mla_op_mov_accum_to_mem: begin
				mem_we = 1'b1;
				mem_wdata = work_accumulator_reg;
			end
			mla_pkg::mla_op_or_mem: work_accumulator_next = work_accumulator_reg | mem_byte;
			mla_pkg::mla_op_or_imm: work_accumulator_next = work_accumulator_reg | operand_imm_reg;
			default: pc_next = pc_reg + `MLA_PC_STEP;
		endcase
		unique case (mla_pkg::mla_op_t'(op_raw))
			mla_pkg::mla_op_and_mem, mla_pkg::mla_op_and_imm, mla_pkg::mla_op_complement_to_acc,
			mla_pkg::mla_op_decrement_to_acc, mla_pkg::mla_op_increment_to_acc,
			mla_pkg::mla_op_or_mem, mla_pkg::mla_op_or_imm:
				zero_next = work_accumulator_next == `MLA_BYTE_ZERO;
			mla_pkg::mla_op_and_to_memory, mla_pkg::mla_op_complement_in_place,
			mla_pkg::mla_op_dec_mem, mla_pkg::mla_op_inc_mem:
				zero_next = mem_wdata == `MLA_BYTE_ZERO;
			default: zero_next = zero_reg;
		endcase
	end

	// Accumulator and operand latches
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			work_accumulator_reg <= `MLA_ACCUM_RST;
			operand_imm_reg <= `MLA_BYTE_ZERO;
			operand_tgt_reg <= `MLA_PC_RST;
		end else if (exec) begin
			work_accumulator_reg <= work_accumulator_next;
		end else if (wr_access && i_paddr == `MLA_OFS_ACCUM) begin
			work_accumulator_reg <= i_pwdata[7:0];
		end else if (wr_access && i_paddr == `MLA_OFS_OPERAND) begin
			operand_imm_reg <= i_pwdata[`MLA_OPND_IMM_LSB +: 8];
			operand_tgt_reg <= i_pwdata[`MLA_OPND_TGT_LSB +: PC_W];
		end
	end

	// Data memory: instruction results and direct software access
	always_ff @(posedge i_clk) begin
		if (exec && mem_we) begin
			dmem[op_addr] <= mem_wdata;
		end else if (wr_access && dmem_hit) begin
			dmem[dmem_idx] <= i_pwdata[7:0];
		end
	end

	// Arithmetic flags; software may preset them through the status word
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			carry_reg <= 1'b0;
			aux_carry_flag_reg <= 1'b0;
			zero_reg <= 1'b0;
			overflow_flag_reg <= 1'b0;
		end else if (exec) begin
			carry_reg <= carry_next;
			zero_reg <= zero_next;
		end else if (wr_access && i_paddr == `MLA_OFS_STATUS) begin
			carry_reg <= i_pwdata[`MLA_ST_C];
			aux_carry_flag_reg <= i_pwdata[`MLA_ST_AUX];
			zero_reg <= i_pwdata[`MLA_ST_Z];
			overflow_flag_reg <= i_pwdata[`MLA_ST_OVFL];
		end
	end

	// Program counter and return stack; the stack wraps when nested too deep
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_reg <= `MLA_PC_RST;
			sp_reg <= '0;
		end else if (exec) begin
			pc_reg <= pc_next;
			if (push) begin
				sp_reg <= sp_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (exec && push) begin
			stack_mem[sp_reg] <= pc_reg + `MLA_PC_STEP;
		end
	end

	// Pre-clear pairing memory
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			preclear_first_reg <= 1'b0;
			preclear_second_reg <= 1'b0;
		end else if (exec) begin
			preclear_first_reg <= preclear_first_next;
			preclear_second_reg <= preclear_second_next;
		end
	end

	// Watchdog prescaler and counter
	assign presc_tick = presc_reg == `MLA_PRESC_DIV;
	assign wdog_overflow = presc_tick && watchdog_counter_reg == `MLA_WDOG_MAX;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_reg <= 16'h0000;
			watchdog_counter_reg <= `MLA_BYTE_ZERO;
		end else if (exec && wdog_clr) begin
			presc_reg <= 16'h0000;
			watchdog_counter_reg <= `MLA_BYTE_ZERO;
		end else if (presc_tick) begin
			presc_reg <= 16'h0000;
			watchdog_counter_reg <= watchdog_counter_reg + `MLA_BYTE_ONE;
		end else begin
			presc_reg <= presc_reg + 16'h0001;
		end
	end

	// Overflow sets time-out unless an instruction clears the watchdog in the same cycle
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_down_flag_reg <= 1'b0;
			timeout_flag_reg <= 1'b0;
		end else begin
			if (exec && enter_halt) begin
				power_down_flag_reg <= 1'b1;
			end else if (exec && flags_clr) begin
				power_down_flag_reg <= 1'b0;
			end
			if (wdog_overflow && !(exec && wdog_clr)) begin
				timeout_flag_reg <= 1'b1;
			end else if (exec && (flags_clr || enter_halt)) begin
				timeout_flag_reg <= 1'b0;
			end
		end
	end

	// Run / power-down state
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= mla_pkg::mla_run;
		end else begin
			unique case (state_reg)
				mla_pkg::mla_run: if (exec && enter_halt) begin
					state_reg <= mla_pkg::mla_halted;
				end
				mla_pkg::mla_halted: if (i_wake) begin
					state_reg <= mla_pkg::mla_run;
				end
				default: state_reg <= mla_pkg::mla_run;
			endcase
		end
	end

	assign o_halted = state_reg == mla_pkg::mla_halted;
	assign o_clk_stop = o_halted;
	assign o_timeout_flag = timeout_flag_reg;

endmodule
`default_nettype wire

//--- tb/mla_exec_unit_properties.sv
`timescale 1ns/100ps
`default_nettype none
module mla_exec_checker (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_wake,
	input wire logic o_halted,
	input wire logic o_clk_stop,
	input wire logic o_timeout_flag
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	logic ins_wr;
	logic pd_wr;
	logic wd_wr;
	assign ins_wr = i_psel && i_penable && i_pwrite && i_paddr == 12'h000;
	assign pd_wr = ins_wr && !o_halted && i_pwdata[5:0] == 6'h0f;
	assign wd_wr = ins_wr && !o_halted && i_pwdata[5:0] == 6'h07;
	property p_ready_now;
		1'b1 |-> o_pready == (i_psel && i_penable);
	endproperty
	a_ready_now: assert property (p_ready_now) else $error("pready not in first access cycle");
	property p_clk_stop;
		o_clk_stop == o_halted;
	endproperty
	a_clk_stop: assert property (p_clk_stop) else $error("clock stop differs from halt");
	property p_halt_enter;
		pd_wr |=> o_halted;
	endproperty
	a_halt_enter: assert property (p_halt_enter) else $error("power-down did not halt");
	property p_halt_to;
		pd_wr |=> !o_timeout_flag;
	endproperty
	a_halt_to: assert property (p_halt_to) else $error("time-out kept on power-down");
	property p_wd_clear;
		wd_wr |=> !o_timeout_flag;
	endproperty
	a_wd_clear: assert property (p_wd_clear) else $error("time-out kept on watchdog clear");
	property p_halt_refuse;
		o_halted && ins_wr |-> o_pslverr;
	endproperty
	a_halt_refuse: assert property (p_halt_refuse) else $error("instruction taken while halted");
	property p_halt_hold;
		o_halted && !i_wake |=> o_halted;
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("left halt without wake");
	property p_halt_cause;
		$rose(o_halted) |-> $past(pd_wr);
	endproperty
	a_halt_cause: assert property (p_halt_cause) else $error("halt without power-down");
	property p_wake_cause;
		$fell(o_halted) |-> $past(i_wake);
	endproperty
	a_wake_cause: assert property (p_wake_cause) else $error("wake without request");
	c_halt: cover property (pd_wr);
	c_wake: cover property ($fell(o_halted));
	c_err: cover property (o_pready && o_pslverr);
endmodule
bind mla_exec_unit mla_exec_checker chk_u (.i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
	.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_wake, .o_halted, .o_clk_stop, .o_timeout_flag);
`default_nettype wire

//--- tb/mla_wake_src.sv
`timescale 1ns/100ps
`default_nettype none
module mla_wake_src (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_halted,
	input wire logic [7:0] i_delay,
	output logic o_wake
);
	logic [7:0] cnt_reg;
	// Delay lets a slow waker leave room for accesses while halted
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_reg <= 8'h00;
		end else if (i_halted) begin
			cnt_reg <= cnt_reg + 8'h01;
		end else begin
			cnt_reg <= 8'h00;
		end
	end
	assign o_wake = i_halted && cnt_reg >= i_delay;
endmodule
`default_nettype wire

//--- tb/test_mla_exec_unit.sv
`timescale 1ns/100ps
`default_nettype none
module test_mla_exec_unit;
	logic clk, nrst, psel, pen, pwr, wake, pready, pslverr, halted, to_flag, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] dly;
	logic [15:0] seed;
	logic [11:0] pc;
	int err_count, check_count;
	mla_exec_unit dut_u (.i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_wake(wake), .o_halted(halted), .o_clk_stop(), .o_timeout_flag(to_flag));
	mla_wake_src ws_u (.i_clk(clk), .i_nrst(nrst), .i_halted(halted), .i_delay(dly), .o_wake(wake));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [19:0] model(input logic [5:0] op, input logic [7:0] acc, input logic [7:0] m,
		input logic [7:0] im, input logic [2:0] b, input logic [3:0] fl);
		logic [7:0] ra, mm;
		logic [4:0] lo, hi;
		logic nc;
		ra = acc;
		mm = m;
		case (op)
			6'h01: ra = acc & m;
			6'h02: ra = acc & im;
			6'h03: mm = acc & m;
			6'h05: mm = 8'h00;
			6'h06: mm[b] = 1'b0;
			6'h0a: mm = ~m;
			6'h0b: ra = ~m;
			6'h0c: begin
				lo = {1'b0, acc[3:0]};
				nc = 1'b0;
				if (lo > 5'h09 || fl[1]) begin
					lo = lo + 5'h06;
					nc = ~fl[1];
				end
				hi = {1'b0, acc[7:4]} + {4'h0, nc};
				if (hi > 5'h09 || fl[0]) begin
					hi = hi + 5'h06;
					fl[0] = 1'b1;
				end
				mm = {hi[3:0], lo[3:0]};
			end
			6'h0d: mm = m - 8'h01;
			6'h0e: ra = m - 8'h01;
			6'h10: mm = m + 8'h01;
			6'h11: ra = m + 8'h01;
			6'h13: ra = m;
			6'h14: ra = im;
			6'h15: mm = acc;
			6'h16: ra = acc | m;
			6'h17: ra = acc | im;
			default: ;
		endcase
		if (op inside {6'h01, 6'h02, 6'h0b, 6'h0e, 6'h11, 6'h16, 6'h17}) fl[2] = ra == 8'h00;
		if (op inside {6'h03, 6'h0a, 6'h0d, 6'h10}) fl[2] = mm == 8'h00;
		return {ra, mm, fl};
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) err_count++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
			err_count++;
		end
	endtask
	task automatic ex(input logic [5:0] op);
		apb(1'b1, 12'h000, {26'h0, op});
	endtask
	task automatic rpc();
		apb(1'b0, 12'h010, 32'h0);
		pc = rd[11:0];
	endtask
	task automatic halt_run(input logic [7:0] d);
		int n;
		n = 0;
		dly <= d;
		rpc();
		ex(6'h0f);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd & 32'h30, 32'h10);
		chk({31'h0, to_flag}, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		chk(rd & 32'hff, 32'h0);
		if (d > 8'h10) begin
			chk({31'h0, halted}, 32'h1);
			ex(6'h13);
			chk({31'h0, er}, 32'h1);
		end
		while (halted !== 1'b0 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, n < 300}, 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd & 32'hfff, {20'h0, pc + 12'h001});
		repeat (600) @(posedge clk);
	endtask
	initial begin
		static logic [5:0] ops [18] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h0a, 6'h0b, 6'h0c, 6'h0d,
			6'h0e, 6'h10, 6'h11, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17};
		logic [7:0] x, m, im;
		logic [3:0] a, fl;
		logic [2:0] b;
		logic [19:0] e;
		int n;
		err_count = 0;
		check_count = 0;
		nrst = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		dly = 8'h01;
		seed = 16'h520a;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (ops[k]) for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			x = seed[7:0];
			im = seed[15:8];
			seed = lfsr(seed);
			// Zero, all-ones, then random data byte
			m = i == 0 ? 8'h00 : i == 1 ? 8'hff : seed[7:0];
			a = seed[11:8];
			b = seed[14:12];
			fl = {seed[15], seed[2:0]};
			apb(1'b1, 12'h040 + {6'h00, a, 2'b00}, {24'h0, m});
			apb(1'b1, 12'h008, {24'h0, x});
			apb(1'b1, 12'h004, {24'h0, im});
			apb(1'b1, 12'h00c, {28'h0, fl});
			rpc();
			apb(1'b1, 12'h000, {12'h0, a, 5'h00, b, 2'b00, ops[k]});
			e = model(ops[k], x, m, im, b, fl);
			apb(1'b0, 12'h008, 32'h0);
			chk(rd & 32'hff, {24'h0, e[19:12]});
			apb(1'b0, 12'h040 + {6'h00, a, 2'b00}, 32'h0);
			chk(rd, {24'h0, e[11:4]});
			apb(1'b0, 12'h00c, 32'h0);
			chk(rd & 32'hf, {28'h0, e[3:0]});
			apb(1'b0, 12'h010, 32'h0);
			chk(rd & 32'hfff, {20'h0, pc + 12'h001});
		end
		$display("data ops test done");
		apb(1'b1, 12'h004, 32'h0abc0000);
		ex(6'h04);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd & 32'hfff, 32'habc);
		chk({28'h0, rd[19:16]}, 32'h1);
		apb(1'b1, 12'h004, 32'h01230000);
		ex(6'h12);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd & 32'hfff, 32'h123);
		apb(1'b0, 12'h030, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		ex(6'h3f);
		chk({31'h0, er}, 32'h1);
		$display("branch and refusal test done");
		halt_run(8'h40);
		ex(6'h08);
		ex(6'h08);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd & 32'h30, 32'h10);
		apb(1'b0, 12'h014, 32'h0);
		chk({31'h0, rd[7:0] != 8'h00}, 32'h1);
		ex(6'h09);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd & 32'h30, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		chk(rd & 32'hff, 32'h0);
		halt_run(8'h01);
		ex(6'h07);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd & 32'h30, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		chk(rd & 32'hff, 32'h0);
		$display("power-down and watchdog test done");
		// Full watchdog wrap takes 256 ticks of 256 clocks
		n = 0;
		while (to_flag !== 1'b1 && n < 66000) begin
			@(posedge clk);
			n++;
		end
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd & 32'h30, 32'h20);
		ex(6'h07);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd & 32'h30, 32'h0);
		chk({31'h0, to_flag}, 32'h0);
		$display("time-out clear test done");
		end_sim();
	end
	initial begin
		#1600000;
		err_count++;
		end_sim();
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
endmodule
`default_nettype wire
